/* hdl/sil_latch_bank.sv */
// Station I/O latch bank: write latches, input buffers, failsafe
`timescale 1ns/1ps
module sil_latch_bank (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       ce,
	sil_bus_if.dev          bus,
	input  wire logic       delayed_reset,
	// Status inputs
	input  wire logic       pa_on,
	input  wire logic       pa_full_power,
	input  wire logic       tx_lock_n,
	input  wire logic       rx_lock_n,
	input  wire logic       tx_loop,
	input  wire logic       rx_loop,
	input  wire logic       rx1_unsquelch,
	input  wire logic       repeater_unsquelch,
	// Option inputs
	input  wire logic       tone_decode_data,
	input  wire logic       battery_revert,
	input  wire logic       overvoltage_alarm,
	input  wire logic       remote_board_type,
	input  wire logic       intercom_request,
	input  wire logic       channel_activity,
	input  wire logic       service_jumper,
	// Command inputs
	input  wire logic [3:0] remote_word,
	input  wire logic       local_talk_request,
	input  wire logic       access_inhibit_switch,
	input  wire logic       force_transmit_switch,
	input  wire logic       tone_disable_switch,
	input  wire logic       repeater_talk_request,
	input  wire logic       wireline_talk_request,
	input  wire logic [3:0] expansion_read_bit,
	// Synthesizer side
	output logic [3:0]      synth_data,
	output logic [2:0]      synth_addr,
	output logic            tx_strobe,
	output logic            rx_strobe,
	// Tone code side
	output logic [4:0]      tone_dac_code,
	output logic            rotate_request,
	// Option controls
	output logic            decode_digital,
	output logic            deviation_reduce,
	output logic            power_reduce,
	output logic            antenna_switch,
	output logic            line_alarm_mix,
	output logic            tx_repeater_mix,
	output logic            squelch_level_sel,
	output logic            squelch_adapt,
	// Expansion bus
	output logic [3:0]      expansion_addr_bit,
	output logic [3:0]      expansion_write_bit_o,
	output logic [3:0]      expansion_write_bit_oe,
	// Station actions
	output logic            pa_key,
	output logic            intercom_line_gate,
	output logic            intercom_speaker_gate,
	output logic            intercom_rx_mix,
	output logic            power_ctrl_inhibit,
	output logic            pa_fail_alarm,
	output logic            id_alarm_inhibit,
	output logic            timeout_inhibit,
	output logic            repeater_key_inhibit,
	output logic            line_cmd_inhibit,
	output logic            tx_audio_mute,
	output logic            tone_strip
);
	// ************************************************************
	// Select decode
	// ************************************************************
	logic       io_space; // Address in I/O window, reset released
	logic       iow;      // Qualified write enable
	logic       ior;      // Qualified read enable
	logic [7:0] syn_ff;   // Synth program latch
	logic [7:0] dac_ff;   // Tone code latch
	logic [7:0] opt_ff;   // Option control latch
	logic [7:0] exp_ff;   // Expansion write latch
	logic       tx_stb_ff;
	logic       rx_stb_ff;
	logic [7:0] rdata_ff; // Read data register
	logic [7:0] nxt_rdata;
	logic       key_ff;   // Failsafe flip-flop
	logic       ic_cancel;

	// Device select: enable plus one low address line
	function automatic logic sel(input logic en, input logic [15:0] a, input int ln);
		sel = en & ~a[ln];
	endfunction

	// Enables gated by window and delayed reset
	assign io_space = bus.io_addr[sil_pkg::LN_A14] & ~bus.io_addr[sil_pkg::LN_A15]
		& ~delayed_reset;
	assign iow = bus.io_wr & io_space;
	assign ior = bus.io_rd & io_space;

	// ************************************************************
	// Write latches
	// ************************************************************
	// Synth latch
	always_ff @(posedge clk) begin
		if (srst) begin
			syn_ff <= sil_pkg::RST_BYTE;
		end else if (ce && sel(iow, bus.io_addr, sil_pkg::LN_SYN)) begin // [R23]
			syn_ff <= bus.io_wdata;
		end
	end

	// Tone code latch
	always_ff @(posedge clk) begin
		if (srst) begin
			dac_ff <= sil_pkg::RST_BYTE;
		end else if (ce && sel(iow, bus.io_addr, sil_pkg::LN_DAC)) begin // [R23]
			dac_ff <= bus.io_wdata;
		end
	end

	// Option latch
	always_ff @(posedge clk) begin
		if (srst) begin
			opt_ff <= sil_pkg::RST_BYTE;
		end else if (ce && sel(iow, bus.io_addr, sil_pkg::LN_OPT_WR)) begin // [R23]
			opt_ff <= bus.io_wdata;
		end
	end

	// Expansion write latch
	always_ff @(posedge clk) begin
		if (srst) begin
			exp_ff <= sil_pkg::RST_BYTE;
		end else if (ce && sel(iow, bus.io_addr, sil_pkg::LN_EXP_WR)) begin // [R23]
			exp_ff <= bus.io_wdata;
		end
	end

	// Strobes: one pulse per strobe write, data-less
	// Strobe lines select when high; every other device address holds both low
	always_ff @(posedge clk) begin
		if (srst) begin
			tx_stb_ff <= 1'b0;
			rx_stb_ff <= 1'b0;
		end else if (ce) begin
			tx_stb_ff <= iow & bus.io_addr[sil_pkg::LN_TX_STB]; // [R24] [R23]
			rx_stb_ff <= iow & bus.io_addr[sil_pkg::LN_RX_STB]; // [R24] [R23]
		end
	end

	// ************************************************************
	// Latch outputs
	// ************************************************************
	assign synth_data    = syn_ff[sil_pkg::SYN_DAT_LSB +: 4]; // [R01]
	assign synth_addr    = syn_ff[sil_pkg::SYN_ADR_LSB +: 3]; // [R01]
	assign tx_strobe     = tx_stb_ff;
	assign rx_strobe     = rx_stb_ff;
	assign tone_dac_code = dac_ff[4:0];                       // [R03]
	assign rotate_request = dac_ff[sil_pkg::DAC_ROT_BIT];      // [R03]
	// Option bits from the latch; power reduce and alarm mix are gated
	assign decode_digital    = opt_ff[sil_pkg::OPT_DIGITAL];   // [R06]
	assign deviation_reduce  = opt_ff[sil_pkg::OPT_DEV_RED];   // [R06]
	assign power_reduce      = opt_ff[sil_pkg::OPT_PWR_RED] & ~service_jumper; // [R06] [R15]
	assign antenna_switch    = opt_ff[sil_pkg::OPT_ANT_SW];    // [R06]
	// Alarm mix blocked while access is inhibited
	assign line_alarm_mix    = opt_ff[sil_pkg::OPT_ALARM] & ~access_inhibit_switch; // [R07] [R17]
	assign tx_repeater_mix   = opt_ff[sil_pkg::OPT_RPTR];      // [R07]
	assign squelch_level_sel = opt_ff[sil_pkg::OPT_SQ_LVL];    // [R08]
	assign squelch_adapt     = opt_ff[sil_pkg::OPT_ADAPT];     // [R08]
	// Expansion: open-collector inverter pulls low for a one bit
	assign expansion_addr_bit     = exp_ff[3:0];                          // [R19]
	assign expansion_write_bit_o  = 4'h0;                                 // [R19]
	assign expansion_write_bit_oe = exp_ff[sil_pkg::EXP_WD_LSB +: 4];     // [R19]

	// ************************************************************
	// Input buffers
	// ************************************************************
	// Read mux, result stands the cycle after the enable
	always_comb begin
		nxt_rdata = rdata_ff;
		if (ior) begin
			nxt_rdata = 8'h00; // No device selected
			if (sel(ior, bus.io_addr, sil_pkg::LN_STATUS)) begin
				nxt_rdata = {repeater_unsquelch, rx1_unsquelch, rx_loop, tx_loop,
					rx_lock_n, tx_lock_n, pa_full_power, pa_on}; // [R09] [R10]
			end else if (sel(ior, bus.io_addr, sil_pkg::LN_OPT_RD)) begin
				nxt_rdata = {service_jumper, channel_activity, intercom_request,
					remote_board_type, overvoltage_alarm, battery_revert,
					rotate_request, tone_decode_data}; // [R04] [R11] [R12]
			end else if (sel(ior, bus.io_addr, sil_pkg::LN_CMD_RD)) begin
				nxt_rdata = {tone_disable_switch, force_transmit_switch,
					access_inhibit_switch, local_talk_request, remote_word}; // [R16]
			end else if (sel(ior, bus.io_addr, sil_pkg::LN_EXP_RD)) begin
				nxt_rdata = {4'h0, expansion_read_bit}; // [R20]
			end
		end
	end

	// Read data register
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_ff <= sil_pkg::RST_BYTE;
		end else if (ce) begin
			rdata_ff <= nxt_rdata;
		end
	end
	assign bus.io_rdata = rdata_ff;

	// ************************************************************
	// Failsafe and station actions
	// ************************************************************
	// Key needs lock, a request and no delayed reset; lock loss aborts
	always_ff @(posedge clk) begin
		if (srst) begin
			key_ff <= 1'b0;
		end else if (ce) begin
			key_ff <= ~tx_lock_n & ~delayed_reset
				& (bus.pa_key_req | force_transmit_switch)
				& ~(intercom_request & local_talk_request & ~ic_cancel); // [R21] [R18] [R13]
		end
	end
	assign pa_key = key_ff & ~tx_lock_n; // [R21]

	// Intercom paths dropped on repeater talk, or on line talk while access is not inhibited
	assign ic_cancel = repeater_talk_request
		| (wireline_talk_request & ~access_inhibit_switch);             // [R14] [R17]
	assign intercom_line_gate    = intercom_request & local_talk_request & ~ic_cancel;  // [R13]
	assign intercom_speaker_gate = intercom_request & ~local_talk_request & ~ic_cancel; // [R13]
	assign intercom_rx_mix       = intercom_request & ~ic_cancel;                       // [R13]
	// Service jumper
	assign power_ctrl_inhibit = service_jumper; // [R15]
	assign pa_fail_alarm      = service_jumper; // [R15]
	// Access inhibit
	assign id_alarm_inhibit     = access_inhibit_switch; // [R17]
	assign timeout_inhibit      = access_inhibit_switch; // [R17]
	assign repeater_key_inhibit = access_inhibit_switch; // [R17]
	assign line_cmd_inhibit     = access_inhibit_switch; // [R17]
	// Forced transmit: carrier only
	assign tx_audio_mute = force_transmit_switch; // [R18]
	assign tone_strip    = force_transmit_switch; // [R18]
endmodule // sil_latch_bank

/* hdl/sil_pkg.sv */
// Shared constants for the station I/O latch bank and its processor end
// Summary of operation
// R01: Synth latch drives four data, three address bits
// R02: Processor writes seven sets, strobing each one
// R03: DAC latch drives five code bits, rotate bit
// R04: Rotate bit loops back into options buffer
// R05: Processor rotates code word every 7440 us
// R06: Options latch holds eight control outputs
// R07: Alarm and repeater bits mix audio paths
// R08: Squelch level and adapt bits steer squelch
// R09: Status returns power and squelch inputs
// R10: Status returns locks and loop sync inputs
// R11: Options buffer returns seven inputs plus the rotate bit
// R12: Options buffer returns board, intercom, activity, service
// R13: Intercom routes audio without keying amplifier
// R14: Repeater or line talk cancels intercom
// R15: Service jumper inhibits power control, raises alarm
// R16: Command buffer returns word, talk, three switches
// R17: Access inhibit blocks ID, alarms, timers, line
// R18: Force transmit keys amplifier, strips audio, tones
// R19: Expansion latch drives address, inverted write data
// R20: Expansion buffer returns four inverted data bits; the code returns them uninverted, upper nibble zero
// R21: Amplifier keys only with lock, request, no reset
// R22: Tickle goes low 6 ms after reset
// R23: Each device selected by enable plus address line
// R24: Synth strobes are one-cycle pulses on write
package sil_pkg;
	// ************************************************************
	// Processor I/O addresses
	// ************************************************************
	localparam logic [15:0] ADR_EXP_RD   = 16'h59FF; // Expansion read buffer
	localparam logic [15:0] ADR_EXP_WR   = 16'h69FF; // Expansion write latch
	localparam logic [15:0] ADR_SYN      = 16'h71FF; // Synth program latch
	localparam logic [15:0] ADR_TX_STB   = 16'h7DFF; // Transmit strobe
	localparam logic [15:0] ADR_RX_STB   = 16'h7BFF; // Receive strobe
	localparam logic [15:0] ADR_DAC      = 16'h78FF; // Tone code latch
	localparam logic [15:0] ADR_STATUS   = 16'h797F; // Status buffer
	localparam logic [15:0] ADR_OPT_WR   = 16'h79BF; // Options latch
	localparam logic [15:0] ADR_OPT_RD   = 16'h79DF; // Options buffer
	localparam logic [15:0] ADR_CMD_RD   = 16'h79EF; // Command buffer
	// Dedicated select lines: active low, but the two strobe lines are active high
	localparam int LN_EXP_RD = 13;
	localparam int LN_EXP_WR = 12;
	localparam int LN_SYN    = 11;
	localparam int LN_TX_STB = 10;
	localparam int LN_RX_STB = 9;
	localparam int LN_DAC    = 8;
	localparam int LN_STATUS = 7;
	localparam int LN_OPT_WR = 6;
	localparam int LN_OPT_RD = 5;
	localparam int LN_CMD_RD = 4;
	localparam int LN_A14    = 14; // Must be high for I/O space
	localparam int LN_A15    = 15; // Must be low for I/O space
	// ************************************************************
	// Latch field layout
	// ************************************************************
	localparam int SYN_DAT_LSB = 0;  // Four data bits
	localparam int SYN_ADR_LSB = 4;  // Three address bits
	localparam int DAC_ROT_BIT = 5;  // Rotate request
	localparam int EXP_WD_LSB  = 4;  // Write data nibble
	localparam int OPT_DIGITAL = 0;  // Decode filter digital
	localparam int OPT_DEV_RED = 1;  // Deviation reduce
	localparam int OPT_PWR_RED = 2;  // Power reduce
	localparam int OPT_ANT_SW  = 3;  // Antenna switch
	localparam int OPT_ALARM   = 4;  // Alarm audio mix
	localparam int OPT_RPTR    = 5;  // Repeater audio mix
	localparam int OPT_SQ_LVL  = 6;  // Remote squelch level
	localparam int OPT_ADAPT   = 7;  // Squelch adapt
	localparam logic [7:0] RST_BYTE = 8'h00;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_MHZ  = 200;
	localparam int ROT_US   = 7440;
	localparam int ROT_CYC  = ROT_US * CLK_MHZ;
	localparam int WDT_MS   = 6;
	localparam int WDT_CYC  = WDT_MS * 1000 * CLK_MHZ;
	localparam int SYN_SETS = 7;
	// ************************************************************
	// Controller software map
	// ************************************************************
	localparam logic [3:0] SW_CTRL  = 4'h0; // Key request, synth start
	localparam logic [3:0] SW_ADDR  = 4'h1; // Bus address
	localparam logic [3:0] SW_WDATA = 4'h2; // Bus write data
	localparam logic [3:0] SW_GO_WR = 4'h3; // Launch bus write
	localparam logic [3:0] SW_GO_RD = 4'h4; // Launch bus read
	localparam logic [3:0] SW_RDATA = 4'h5; // Bus read result
	localparam logic [3:0] SW_STAT  = 4'h6; // Busy, rotate due, tickle
	localparam logic [3:0] SW_CLR   = 4'h7; // Clear rotate due
	localparam logic [3:0] SW_SET0  = 4'h8; // Synth sets 8..E
	localparam int CTL_KEY = 0;
	localparam int CTL_GO  = 1;
	localparam int CTL_RX  = 2;
endpackage

/* hdl/sil_bus_if.sv */
// Processor bus between the controller and the I/O latch bank
`timescale 1ns/1ps
interface sil_bus_if;
	logic [15:0] io_addr;    // Latched address
	logic [7:0]  io_wdata;   // Write data
	logic        io_wr;      // Write enable, one cycle
	logic        io_rd;      // Read enable, one cycle
	logic [7:0]  io_rdata;   // Read data, cycle after io_rd
	logic        pa_key_req; // Processor key request level
	modport dev  (input io_addr, io_wdata, io_wr, io_rd, pa_key_req, output io_rdata);
	modport host (output io_addr, io_wdata, io_wr, io_rd, pa_key_req, input io_rdata);
endinterface

/* hdl/sil_ctrl.sv */
// Processor end: drives the I/O bus for software, sequences synth loads
`timescale 1ns/1ps
module sil_ctrl #(
	parameter int ROT_CYC = sil_pkg::ROT_CYC, // Rotate period in cycles
	parameter int WDT_CYC = sil_pkg::WDT_CYC  // Tickle delay in cycles
) (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       ce,
	sil_bus_if.host         bus,
	input  wire logic [3:0] sw_addr,
	input  wire logic [15:0] sw_wdata,
	input  wire logic       sw_wr,
	input  wire logic       sw_rd,
	output logic [15:0]     sw_rdata,
	output logic            watchdog_tickle
);
	// ************************************************************
	// State
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000, // Waiting
		ST_RDW   = 3'b001, // Read data due
		ST_SYN_W = 3'b010, // Writing one set
		ST_SYN_S = 3'b011, // Strobing that set
		ST_RD_CAP = 3'b100 // Read byte now stands on the bus
	} sil_st_e;
	sil_st_e     st_ff;
	logic [15:0] adr_ff;      // Bus address register
	logic [7:0]  wd_ff;       // Bus write data register
	logic [7:0]  rd_ff;       // Last read result
	logic [2:0]  ctl_ff;      // Control bits
	logic [6:0]  set_ff [sil_pkg::SYN_SETS]; // Synth sets
	logic [2:0]  idx_ff;      // Set index
	logic [15:0] io_addr_ff;
	logic [7:0]  io_wdata_ff;
	logic        io_wr_ff;
	logic        io_rd_ff;
	logic [20:0] rot_cnt_ff;  // Rotate timer
	logic        rot_due_ff;  // Sticky rotate flag
	logic [20:0] wdt_cnt_ff;  // Tickle delay
	logic        wdt_done_ff;
	logic        busy;
	logic        rot_tick;
	logic [15:0] rdata_ff;

	assign busy = (st_ff != ST_IDLE);
	assign rot_tick = (rot_cnt_ff == 21'(ROT_CYC - 1));

	// Software registers
	always_ff @(posedge clk) begin
		if (srst) begin
			adr_ff <= 16'h0000;
			wd_ff  <= 8'h00;
			ctl_ff <= 3'h0;
			for (int i = 0; i < sil_pkg::SYN_SETS; i++) begin
				set_ff[i] <= 7'h00;
			end
		end else if (ce && sw_wr) begin
			unique case (sw_addr)
				sil_pkg::SW_CTRL:  ctl_ff <= sw_wdata[2:0];
				sil_pkg::SW_ADDR:  adr_ff <= sw_wdata;
				sil_pkg::SW_WDATA: wd_ff  <= sw_wdata[7:0];
				default: begin
					if (sw_addr >= sil_pkg::SW_SET0 && !busy) begin
						set_ff[3'(sw_addr - sil_pkg::SW_SET0)] <= sw_wdata[6:0];
					end
				end
			endcase
			if (sw_addr == sil_pkg::SW_CTRL && busy) begin
				ctl_ff[sil_pkg::CTL_RX] <= ctl_ff[sil_pkg::CTL_RX]; // Keep target mid-load
			end
		end
	end
	assign bus.pa_key_req = ctl_ff[sil_pkg::CTL_KEY];

	// ************************************************************
	// Bus engine
	// ************************************************************
	// One cycle per access; synth load writes then strobes each set
	always_ff @(posedge clk) begin
		if (srst) begin
			st_ff       <= ST_IDLE;
			idx_ff      <= 3'h0;
			io_addr_ff  <= 16'hFFFF;
			io_wdata_ff <= 8'h00;
			io_wr_ff    <= 1'b0;
			io_rd_ff    <= 1'b0;
			rd_ff       <= 8'h00;
		end else if (ce) begin
			io_wr_ff <= 1'b0;
			io_rd_ff <= 1'b0;
			unique case (st_ff)
				ST_IDLE: begin
					if (sw_wr && sw_addr == sil_pkg::SW_GO_WR) begin
						io_addr_ff  <= adr_ff;
						io_wdata_ff <= wd_ff;
						io_wr_ff    <= 1'b1;
					end else if (sw_wr && sw_addr == sil_pkg::SW_GO_RD) begin
						io_addr_ff <= adr_ff;
						io_rd_ff   <= 1'b1;
						st_ff      <= ST_RDW;
					end else if (sw_wr && sw_addr == sil_pkg::SW_CTRL
						&& sw_wdata[sil_pkg::CTL_GO]) begin
						idx_ff <= 3'h0;
						st_ff  <= ST_SYN_W;
					end
				end
				// Device registers the byte on this edge; take it on the next
				ST_RDW: begin
					st_ff <= ST_RD_CAP;
				end
				ST_RD_CAP: begin
					rd_ff <= bus.io_rdata;
					st_ff <= ST_IDLE;
				end
				ST_SYN_W: begin
					io_addr_ff  <= sil_pkg::ADR_SYN;
					io_wdata_ff <= {1'b0, set_ff[idx_ff]};
					io_wr_ff    <= 1'b1;
					st_ff       <= ST_SYN_S;
				end
				ST_SYN_S: begin
					io_addr_ff <= ctl_ff[sil_pkg::CTL_RX] ? sil_pkg::ADR_RX_STB
						: sil_pkg::ADR_TX_STB;
					io_wr_ff   <= 1'b1; // [R02]
					idx_ff     <= idx_ff + 3'h1;
					st_ff      <= (idx_ff == 3'(sil_pkg::SYN_SETS - 1)) ? ST_IDLE
						: ST_SYN_W; // [R02]
				end
			endcase
		end
	end
	assign bus.io_addr  = io_addr_ff;
	assign bus.io_wdata = io_wdata_ff;
	assign bus.io_wr    = io_wr_ff;
	assign bus.io_rd    = io_rd_ff;

	// ************************************************************
	// Timers
	// ************************************************************
	// Rotate pacing; set wins over clear
	always_ff @(posedge clk) begin
		if (srst) begin
			rot_cnt_ff <= 21'h0;
			rot_due_ff <= 1'b0;
		end else if (ce) begin
			rot_cnt_ff <= rot_tick ? 21'h0 : rot_cnt_ff + 21'h1; // [R05]
			if (rot_tick) begin
				rot_due_ff <= 1'b1; // [R05]
			end else if (sw_wr && sw_addr == sil_pkg::SW_CLR && sw_wdata[0]) begin
				rot_due_ff <= 1'b0;
			end
		end
	end

	// Tickle held high, pulled low after delay from reset release
	always_ff @(posedge clk) begin
		if (srst) begin
			wdt_cnt_ff  <= 21'h0;
			wdt_done_ff <= 1'b0;
		end else if (ce && !wdt_done_ff) begin
			wdt_cnt_ff  <= wdt_cnt_ff + 21'h1;
			wdt_done_ff <= (wdt_cnt_ff == 21'(WDT_CYC - 1)); // [R22]
		end
	end
	assign watchdog_tickle = ~wdt_done_ff; // [R22]

	// Software read port, data one cycle later
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_ff <= 16'h0000;
		end else if (ce && sw_rd) begin
			unique case (sw_addr)
				sil_pkg::SW_CTRL:  rdata_ff <= {13'h0, ctl_ff};
				sil_pkg::SW_ADDR:  rdata_ff <= adr_ff;
				sil_pkg::SW_WDATA: rdata_ff <= {8'h00, wd_ff};
				sil_pkg::SW_RDATA: rdata_ff <= {8'h00, rd_ff};
				sil_pkg::SW_STAT:  rdata_ff <= {13'h0, wdt_done_ff, rot_due_ff, busy};
				default:           rdata_ff <= 16'h0000;
			endcase
		end
	end
	assign sw_rdata = rdata_ff;
endmodule // sil_ctrl

/* sim/sil_bus_asserts.sv */
// Bus checks between controller and latch bank
`timescale 1ns/1ps
module sil_bus_asserts (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic [15:0] io_addr,
	input wire logic        io_wr,
	input wire logic        io_rd,
	input wire logic [7:0]  io_rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// Synth set write, then its strobe
	sequence syn_set;
		io_wr && io_addr == sil_pkg::ADR_SYN;
	endsequence
	sequence syn_stb;
		io_wr && (io_addr == sil_pkg::ADR_TX_STB || io_addr == sil_pkg::ADR_RX_STB);
	endsequence
	chk_no_dual_strobe: assert property (!(io_wr && io_rd))
		else $error("read and write together");
	chk_io_space: assert property ((io_wr || io_rd) |-> io_addr[14] && !io_addr[15])
		else $error("access outside io space");
	chk_unmapped_zero: assert property (io_rd && io_addr == 16'h79FF |=> io_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_exp_upper_zero: assert property (io_rd && io_addr == sil_pkg::ADR_EXP_RD |=>
		io_rdata[7:4] == 4'h0) else $error("expansion upper nibble set");
	chk_rdata_holds: assert property (!io_rd |=> $stable(io_rdata))
		else $error("read data moved without read");
	chk_synth_pair: assert property (syn_set |=> syn_stb)
		else $error("synth set without strobe");
	chk_strobe_after_set: assert property (syn_stb |-> $past(io_wr) &&
		$past(io_addr) == sil_pkg::ADR_SYN) else $error("strobe without set");
	chk_read_spacing: assert property (io_rd |=> !io_rd [*2])
		else $error("reads too close");
endmodule // sil_bus_asserts

/* sim/sil_latch_bank_tb.sv */
// Self-checking bench for controller and latch bank pair
`timescale 1ns/1ps
module sil_latch_bank_tb;
	logic clk = 0, srst = 1, ce = 1, delayed_reset = 0; // Clock, reset, ties
	logic [28:0] ins = 29'h0; // Packed station inputs
	logic [3:0] sw_addr = 4'h0, remote_word, expansion_read_bit;
	logic [15:0] sw_wdata = 16'h0000, sw_rdata, rd; // Software port
	logic sw_wr = 0, sw_rd = 0, watchdog_tickle;
	logic pa_on, pa_full_power, tx_lock_n, rx_lock_n, tx_loop, rx_loop, rx1_unsquelch;
	logic repeater_unsquelch, tone_decode_data, battery_revert, overvoltage_alarm;
	logic remote_board_type, intercom_request, channel_activity, service_jumper;
	logic local_talk_request, access_inhibit_switch, force_transmit_switch;
	logic tone_disable_switch, repeater_talk_request, wireline_talk_request;
	logic [3:0] synth_data, expansion_addr_bit, expansion_write_bit_o, expansion_write_bit_oe;
	logic [2:0] synth_addr;
	logic [4:0] tone_dac_code;
	logic tx_strobe, rx_strobe, rotate_request, decode_digital, deviation_reduce;
	logic power_reduce, antenna_switch, line_alarm_mix, tx_repeater_mix, squelch_level_sel;
	logic squelch_adapt, pa_key, intercom_line_gate, intercom_speaker_gate, intercom_rx_mix;
	logic power_ctrl_inhibit, pa_fail_alarm, id_alarm_inhibit, timeout_inhibit;
	logic repeater_key_inhibit, line_cmd_inhibit, tx_audio_mute, tone_strip;
	int fail_count = 0, tests_run = 0, ntx = 0, nrx = 0; // Counters
	assign {expansion_read_bit, wireline_talk_request, repeater_talk_request,
		tone_disable_switch, force_transmit_switch, access_inhibit_switch, local_talk_request,
		remote_word, service_jumper, channel_activity, intercom_request, remote_board_type,
		overvoltage_alarm, battery_revert, tone_decode_data, repeater_unsquelch,
		rx1_unsquelch, rx_loop, tx_loop, rx_lock_n, tx_lock_n, pa_full_power, pa_on} = ins;
	sil_bus_if bus ();
	sil_latch_bank u_sil_latch_bank (.*);
	sil_ctrl #(.ROT_CYC(50), .WDT_CYC(20)) u_sil_ctrl (.*);
	sil_bus_asserts u_sil_bus_asserts (.clk(clk), .srst(srst), .io_addr(bus.io_addr),
		.io_wr(bus.io_wr), .io_rd(bus.io_rd), .io_rdata(bus.io_rdata));
	always #2.5 clk = ~clk;
	// Strobe pulse counters
	always @(posedge clk) begin
		if (tx_strobe === 1'b1) ntx++;
		if (rx_strobe === 1'b1) nrx++;
	end
	// ************************************************************
	// Shared tasks
	// ************************************************************
	task report_and_stop;
		if (fail_count == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task ck(input string n, input logic [15:0] e, input logic [15:0] s);
		tests_run++;
		if (e !== s) begin
			$display("mismatch %s expected %h seen %h", n, e, s);
			fail_count++;
		end
	endtask
	// One software strobe, result caught in rd
	task sw(input logic [3:0] a, input logic [15:0] d, input logic w);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= w;
		sw_rd <= !w;
		@(posedge clk) #1 rd = sw_rdata;
		sw_wr <= 0;
		sw_rd <= 0;
		@(posedge clk) #1;
	endtask
	task dw(input logic [15:0] ad, input logic [15:0] d);
		sw(4'h1, ad, 1);
		sw(4'h2, d, 1);
		sw(4'h3, 16'h0000, 1);
		@(posedge clk) #1;
	endtask
	task dr(input logic [15:0] ad);
		sw(4'h1, ad, 1);
		sw(4'h4, 16'h0000, 1);
		repeat (2) @(posedge clk);
		sw(4'h5, 16'h0000, 0);
	endtask
	task si(input logic [28:0] v);
		@(posedge clk) ins <= v;
		#1;
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task t_latch;
		for (int k = 0; k < 2; k++) begin
			dw(sil_pkg::ADR_OPT_WR, k ? 16'h005A : 16'h00A5);
			ck("options", k ? 16'h5A : 16'hA5, {squelch_adapt, squelch_level_sel,
				tx_repeater_mix, line_alarm_mix, antenna_switch, power_reduce,
				deviation_reduce, decode_digital});
		end
		dw(sil_pkg::ADR_EXP_WR, 16'h00A3);
		ck("exp latch", 16'hA3, {expansion_write_bit_oe, expansion_addr_bit});
		ck("exp pin", 16'h0, expansion_write_bit_o);
	endtask
	task t_rd;
		logic [28:0] v;
		for (int k = 0; k < 2; k++) begin
			v = 29'h1ABCD5E ^ {29{k[0]}};
			si(v);
			dw(sil_pkg::ADR_DAC, k ? 16'h0000 : 16'h003F);
			ck("dac", k ? 16'h0 : 16'h3F, {rotate_request, tone_dac_code});
			dr(sil_pkg::ADR_STATUS);
			ck("status", v[7:0], rd);
			dr(sil_pkg::ADR_OPT_RD);
			ck("opt in", {v[14:9], !k[0], v[8]}, rd);
			dr(sil_pkg::ADR_CMD_RD);
			ck("cmd in", v[22:15], rd);
			dr(sil_pkg::ADR_EXP_RD);
			ck("exp in", v[28:25], rd);
		end
		dr(16'h79FF);
		ck("unmapped", 16'h0, rd);
	endtask
	task t_synth;
		si(29'h0);
		for (int i = 0; i < 7; i++) sw(4'(8 + i), 16'(i * 16 + 9 - i), 1);
		ntx = 0;
		nrx = 0;
		sw(4'h0, 16'h0002, 1);
		repeat (30) @(posedge clk) #1;
		ck("tx strobes", 7, ntx);
		ck("synth word", 16'h63, {synth_addr, synth_data});
		sw(4'h0, 16'h0006, 1);
		repeat (30) @(posedge clk) #1;
		ck("rx strobes", 7, nrx);
		ck("tx idle", 7, ntx);
		sw(4'h6, 16'h0000, 0);
		ck("stat", 16'h6, rd);
	endtask
	task t_key;
		sw(4'h0, 16'h0001, 1);
		repeat (3) @(posedge clk) #1;
		ck("key locked", 1, pa_key);
		si(29'h0000004);
		ck("key unlocked", 0, pa_key);
		sw(4'h0, 16'h0000, 1);
		si(29'h0200000);
		repeat (3) @(posedge clk) #1;
		ck("force key", 16'h7, {pa_key, tone_strip, tx_audio_mute});
		delayed_reset <= 1;
		repeat (2) @(posedge clk) #1;
		ck("key reset", 0, pa_key);
		delayed_reset <= 0;
		si(29'h0081000);
		ck("ic talk", 16'h3, {intercom_line_gate, intercom_rx_mix});
		si(29'h0881000);
		ck("ic rptr", 0, intercom_line_gate);
		si(29'h0001000);
		ck("ic alone", 1, intercom_speaker_gate);
		si(29'h1001000);
		ck("ic line", 0, intercom_speaker_gate);
		si(29'h0004000);
		ck("service", 16'h3, {power_ctrl_inhibit, pa_fail_alarm});
		si(29'h0100000);
		ck("access", 16'hF, {id_alarm_inhibit, timeout_inhibit,
			repeater_key_inhibit, line_cmd_inhibit});
	endtask
	// Watchdog against a hang
	initial begin
		#200000;
		fail_count++;
		report_and_stop;
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		srst <= 0;
		@(posedge clk) #1;
		ck("tickle high", 1, watchdog_tickle);
		t_latch;
		t_rd;
		t_synth;
		t_key;
		ck("tickle low", 0, watchdog_tickle);
		report_and_stop;
	end
endmodule // sil_latch_bank_tb
